//--- src/smc_pkg.sv
// Shared constants, types and frame-format helpers for the serial unit
package smc_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  //////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [2:0] OFF_MODE = 3'h0;
  localparam logic [2:0] OFF_CTRL = 3'h1;
  localparam logic [2:0] OFF_BAUD = 3'h2;
  localparam logic [2:0] OFF_TXDATA = 3'h3;
  localparam logic [2:0] OFF_RXDATA = 3'h4;
  localparam logic [2:0] OFF_STATUS = 3'h5;
  localparam logic [2:0] OFF_CLEAR = 3'h6;
  localparam logic [2:0] OFF_IRQEN = 3'h7;

  // Mode register fields
  localparam int MODE_SYNC = 7;
  localparam int MODE_CHR = 6;
  localparam int MODE_PE = 5;
  localparam int MODE_ODD = 4;
  localparam int MODE_STOP = 3;
  localparam int MODE_MP = 2;

  // Control register fields
  localparam int CTRL_TE = 5;
  localparam int CTRL_RE = 4;
  localparam int CTRL_MPBT = 2;
  localparam int CTRL_CLOCK_ENABLE_HI = 1;
  localparam int CTRL_CLOCK_ENABLE_LO = 0;

  // Status, clear and interrupt enable share this layout
  localparam int ST_RXFULL = 0;
  localparam int ST_TXEMPTY = 1;
  localparam int ST_TXEND = 2;
  localparam int ST_OVR = 3;
  localparam int ST_FRM = 4;
  localparam int ST_PAR = 5;
  localparam int ST_BRK = 6;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] IRQEN_RST = 8'h00;

  // Cycle counts in oversample ticks and bits
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_SAMPLE = 4'h7;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [3:0] SHORT_BITS = 4'h5;
  localparam logic [3:0] MID_BITS = 4'h7;

  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} smc_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_RECV = 2'b10} smc_rx_state_t;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] fmt_data_bits(input logic [7:0] mode);
    if (mode[MODE_SYNC])
      return SYNC_BITS;
    else if (mode[MODE_MP] & mode[MODE_PE])
      return SHORT_BITS;
    else
      return mode[MODE_CHR] ? MID_BITS : SYNC_BITS;
  endfunction

  function automatic logic fmt_has_parity(input logic [7:0] mode);
    return !mode[MODE_SYNC] & mode[MODE_PE] &
           (!mode[MODE_MP] | mode[MODE_CHR]);
  endfunction

  function automatic logic fmt_has_mpb(input logic [7:0] mode);
    return !mode[MODE_SYNC] & mode[MODE_MP] & !mode[MODE_PE];
  endfunction

  function automatic logic [7:0] fmt_mask(input logic [3:0] n);
    return 8'hff >> (SYNC_BITS - n);
  endfunction

  function automatic logic fmt_parity_bit(input logic [7:0] data,
                                          input logic [3:0] n,
                                          input logic odd);
    return (^(data & fmt_mask(n))) ^ odd;
  endfunction

endpackage

//--- src/smc_clk_if.sv
// Clock-source bundle between the serial core and its clock unit
`timescale 1ns/1ps
interface smc_clk_if;
  logic sync_mode;
  logic ext_clk;
  logic [7:0] divisor;
  logic run;
  logic tick16;
  logic ser_rise;
  logic ser_fall;
  logic ser_level;

  modport gen (input sync_mode, ext_clk, divisor, run,
               output tick16, ser_rise, ser_fall, ser_level);
  modport core (output sync_mode, ext_clk, divisor, run,
                input tick16, ser_rise, ser_fall, ser_level);
endinterface

//--- src/smc_clock_unit.sv
// Baud-rate divider and serial clock source selection
`timescale 1ns/1ps
module smc_clock_unit (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Serial clock pin level
  input wire logic i_sck,
  // Core side
  smc_clk_if.gen clk
);
  import smc_pkg::*;

  logic [7:0] div_cnt_r;
  logic div_tick;
  logic pin_prev_r;
  logic pin_rise;
  logic pin_fall;
  logic int_level_r;
  logic toggle_en;

  //////////////////////////////////////////////////////////////////////////
  assign div_tick = (div_cnt_r == 8'h00);

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset)
      div_cnt_r <= 8'h00;
    else if (div_tick)
      div_cnt_r <= clk.divisor;
    else
      div_cnt_r <= div_cnt_r - 8'h01;
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset)
      pin_prev_r <= 1'b1;
    else
      pin_prev_r <= i_sck;
  end

  assign pin_rise = i_sck & !pin_prev_r;
  assign pin_fall = !i_sck & pin_prev_r;

  // Stops only at high so the idle serial clock never glitches low
  assign toggle_en = clk.sync_mode & !clk.ext_clk & div_tick &
                     (clk.run | !int_level_r);

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset)
      int_level_r <= 1'b1;
    else if (!clk.sync_mode | clk.ext_clk)
      int_level_r <= 1'b1;
    else if (toggle_en)
      int_level_r <= !int_level_r;
  end

  //////////////////////////////////////////////////////////////////////////
  // external clock bypasses divider
  assign clk.tick16 = clk.ext_clk ? pin_rise : div_tick;
  assign clk.ser_rise = clk.ext_clk ? pin_rise : (toggle_en & !int_level_r);
  assign clk.ser_fall = clk.ext_clk ? pin_fall : (toggle_en & int_level_r);
  assign clk.ser_level = int_level_r;

endmodule

//--- src/smc_serial_unit.sv
// Serial unit: mode, clock source, transmitter, receiver and interrupts
// Contract
// - Synchronous mode always sends 8 data bits, no parity, MPB or stop.
// - Asynchronous length: 8 bits, 7 with length bit, 5 with MP and PE.
// - Optional parity, multiprocessor bit and second stop bit per mode.
// - Asynchronous receive flags framing, parity, overrun and break.
// - Synchronous receive flags overrun only.
// - Async internal clock; clock select 01 drives bit-rate clock out.
// - Sync: internal clock driven out, external clock taken from pin.
// - Internal clock source always comes from the baud divider.
// - Good character moves to receive data and sets receive-full.
// - Load of transmit shift register sets transmit-empty.
// - Last bit sent with transmit-empty set raises transmit-end.
// - Async receive syncs on start edge, samples on eighth tick.
// - LSB first, low start bit, high stop bits, idle line high.
// - Clearing transmit enable forces transmit-empty to one.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
module smc_serial_unit (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [smc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [smc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [smc_pkg::DATA_W-1:0] o_rdata,
  // Serial pins
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe_n,
  // Interrupt
  output logic o_irq
);
  import smc_pkg::*;

  logic [7:0] serial_mode_reg_r;
  logic [7:0] serial_control_reg_r;
  logic [7:0] baud_r;
  logic [7:0] transmit_data_reg_r;
  logic [7:0] receive_data_reg_r;
  logic [7:0] irqen_r;
  logic receive_full_flag_r;
  logic transmit_empty_flag_r;
  logic transmit_end_flag_r;
  logic overrun_error_flag_r;
  logic framing_error_flag_r;
  logic parity_error_flag_r;
  logic break_flag_r;
  logic [7:0] status_vec;
  logic [7:0] rd_mux;
  logic sel_mode, sel_ctrl, sel_baud, sel_tx, sel_clear, sel_irqen;
  logic wr_clear;
  logic [7:0] clr_bits;
  logic sync_mode_select;
  logic transmit_enable;
  logic receive_enable;
  logic [3:0] data_bits;
  logic has_extra;

  smc_clk_if clk_bus ();

  smc_clock_unit u_clock (
    .i_core_clk (i_core_clk),
    .i_reset (i_reset),
    .i_sck (i_sck),
    .clk (clk_bus.gen)
  );

  assign sync_mode_select = serial_mode_reg_r[MODE_SYNC];
  assign transmit_enable = serial_control_reg_r[CTRL_TE];
  assign receive_enable = serial_control_reg_r[CTRL_RE];
  assign data_bits = fmt_data_bits(serial_mode_reg_r);
  assign has_extra = fmt_has_parity(serial_mode_reg_r) |
                     fmt_has_mpb(serial_mode_reg_r);

  //////////////////////////////////////////////////////////////////////////
  // Register port decode
  always_comb begin
    sel_mode = 1'b0;
    sel_ctrl = 1'b0;
    sel_baud = 1'b0;
    sel_tx = 1'b0;
    sel_clear = 1'b0;
    sel_irqen = 1'b0;
    if (i_addr == OFF_MODE)
      sel_mode = 1'b1;
    else if (i_addr == OFF_CTRL)
      sel_ctrl = 1'b1;
    else if (i_addr == OFF_BAUD)
      sel_baud = 1'b1;
    else if (i_addr == OFF_TXDATA)
      sel_tx = 1'b1;
    else if (i_addr == OFF_CLEAR)
      sel_clear = 1'b1;
    else if (i_addr == OFF_IRQEN)
      sel_irqen = 1'b1;
  end

  assign wr_clear = i_wr & sel_clear;
  assign clr_bits = wr_clear ? i_wdata : 8'h00;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      serial_mode_reg_r <= MODE_RST;
      serial_control_reg_r <= CTRL_RST;
      baud_r <= BAUD_RST;
      transmit_data_reg_r <= 8'h00;
      irqen_r <= IRQEN_RST;
    end else if (i_wr) begin
      if (sel_mode)
        serial_mode_reg_r <= i_wdata;
      if (sel_ctrl)
        serial_control_reg_r <= i_wdata;
      if (sel_baud)
        baud_r <= i_wdata;
      if (sel_tx)
        transmit_data_reg_r <= i_wdata;
      if (sel_irqen)
        irqen_r <= i_wdata;
    end
  end

  assign status_vec = {1'b0, break_flag_r, parity_error_flag_r,
                       framing_error_flag_r, overrun_error_flag_r,
                       transmit_end_flag_r, transmit_empty_flag_r,
                       receive_full_flag_r};

  always_comb begin
    if (i_addr == OFF_MODE)
      rd_mux = serial_mode_reg_r;
    else if (i_addr == OFF_CTRL)
      rd_mux = serial_control_reg_r;
    else if (i_addr == OFF_BAUD)
      rd_mux = baud_r;
    else if (i_addr == OFF_TXDATA)
      rd_mux = transmit_data_reg_r;
    else if (i_addr == OFF_RXDATA)
      rd_mux = receive_data_reg_r;
    else if (i_addr == OFF_STATUS)
      rd_mux = status_vec;
    else if (i_addr == OFF_IRQEN)
      rd_mux = irqen_r;
    else
      rd_mux = 8'h00;
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset)
      o_rdata <= 8'h00;
    else
      o_rdata <= i_rd ? rd_mux : 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock source hookup
  assign clk_bus.sync_mode = sync_mode_select;
  assign clk_bus.ext_clk = serial_control_reg_r[CTRL_CLOCK_ENABLE_HI];
  assign clk_bus.divisor = baud_r;

  //////////////////////////////////////////////////////////////////////////
  // Transmitter
  smc_tx_state_t tx_state_r;
  logic [11:0] tx_frame_r;
  logic [3:0] tx_left_r;
  logic [3:0] tx_os_r;
  logic tx_rose_r;
  logic [11:0] load_frame;
  logic [3:0] load_len;
  logic [3:0] extra_pos;
  logic tx_bit_end;
  logic tx_frame_end;
  logic tx_next_ready;
  logic tx_start;
  logic tx_load;

  assign clk_bus.run = (tx_state_r == TX_SEND) | receive_enable;

  always_comb begin
    load_frame = 12'hfff;
    extra_pos = data_bits + 4'h1;
    if (sync_mode_select) begin
      load_frame[7:0] = transmit_data_reg_r;
      load_len = SYNC_BITS;
    end else begin
      load_frame[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (i < int'(data_bits))
          load_frame[i + 1] = transmit_data_reg_r[i];
      end
      if (fmt_has_parity(serial_mode_reg_r))
        load_frame[extra_pos] = fmt_parity_bit(transmit_data_reg_r,
            data_bits, serial_mode_reg_r[MODE_ODD]);
      else if (fmt_has_mpb(serial_mode_reg_r))
        load_frame[extra_pos] = serial_control_reg_r[CTRL_MPBT];
      load_len = extra_pos + {3'h0, has_extra} + 4'h1 +
                 {3'h0, serial_mode_reg_r[MODE_STOP]};
    end
  end

  assign tx_bit_end = sync_mode_select ? clk_bus.ser_rise :
                      (clk_bus.tick16 & (tx_os_r == OS_LAST));
  assign tx_frame_end = (tx_state_r == TX_SEND) & tx_bit_end &
                        (tx_left_r == 4'h1);
  assign tx_next_ready = transmit_enable & !transmit_empty_flag_r;
  // Async frames start on the bit-clock boundary so the output clock lines up
  assign tx_start = (tx_state_r == TX_IDLE) & tx_next_ready &
                    (sync_mode_select | tx_bit_end);
  assign tx_load = tx_start | (tx_frame_end & tx_next_ready);

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset)
      tx_os_r <= 4'h0;
    else if (sync_mode_select)
      tx_os_r <= 4'h0;
    else if (clk_bus.tick16)
      tx_os_r <= tx_os_r + 4'h1;
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_state_r <= TX_IDLE;
      tx_frame_r <= 12'hfff;
      tx_left_r <= 4'h0;
      tx_rose_r <= 1'b0;
    end else if (!transmit_enable) begin
      tx_state_r <= TX_IDLE;
      tx_frame_r <= 12'hfff;
      tx_rose_r <= 1'b0;
    end else if (tx_load) begin
      tx_state_r <= TX_SEND;
      tx_frame_r <= load_frame;
      tx_left_r <= load_len;
      tx_rose_r <= 1'b0;
    end else if (tx_frame_end) begin
      tx_state_r <= TX_IDLE;
      tx_frame_r <= 12'hfff;
    end else if (tx_state_r == TX_SEND) begin
      if (tx_bit_end)
        tx_left_r <= tx_left_r - 4'h1;
      if (!sync_mode_select & tx_bit_end)
        tx_frame_r <= {1'b1, tx_frame_r[11:1]};
      if (sync_mode_select & clk_bus.ser_rise)
        tx_rose_r <= 1'b1;
      // Sync data changes on the falling edge after each sample
      if (sync_mode_select & clk_bus.ser_fall & tx_rose_r) begin
        tx_frame_r <= {1'b1, tx_frame_r[11:1]};
        tx_rose_r <= 1'b0;
      end
    end
  end

  assign o_txd = tx_frame_r[0];

  // transmit-empty flag, set wins over clear
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset)
      transmit_empty_flag_r <= 1'b1;
    else if (tx_load | !transmit_enable)
      transmit_empty_flag_r <= 1'b1;
    else if ((i_wr & sel_tx) | clr_bits[ST_TXEMPTY])
      transmit_empty_flag_r <= 1'b0;
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset)
      transmit_end_flag_r <= 1'b1;
    else if (tx_frame_end & !tx_next_ready)
      transmit_end_flag_r <= 1'b1;
    else if ((i_wr & sel_tx) | clr_bits[ST_TXEND])
      transmit_end_flag_r <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Receiver
  smc_rx_state_t rx_state_r;
  logic [3:0] rx_os_r;
  logic [3:0] rx_idx_r;
  logic [11:0] rx_buf_r;
  logic rx_armed_r;
  logic rx_in_start_r;
  logic [11:0] rx_word;
  logic [3:0] rx_last;
  logic rx_async_sample;
  logic rx_sync_sample;
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_frm_err;
  logic rx_par_err;
  logic rx_break;

  assign rx_last = sync_mode_select ? (SYNC_BITS - 4'h1) :
                   (data_bits + {3'h0, has_extra});
  assign rx_async_sample = !sync_mode_select & (rx_state_r == RX_RECV) &
                           clk_bus.tick16 & (rx_os_r == OS_SAMPLE);
  assign rx_sync_sample = sync_mode_select & receive_enable &
                          clk_bus.ser_rise;
  assign rx_done = (rx_sync_sample | (rx_async_sample & !rx_in_start_r)) &
                   (rx_idx_r == rx_last);

  always_comb begin
    rx_word = rx_buf_r;
    rx_word[rx_idx_r] = i_rxd;
  end

  assign rx_data = rx_word[7:0] & fmt_mask(data_bits);
  // error checks only in async mode
  assign rx_frm_err = !sync_mode_select & !i_rxd;
  assign rx_par_err = fmt_has_parity(serial_mode_reg_r) &
      (rx_word[data_bits] != fmt_parity_bit(rx_data, data_bits,
                                            serial_mode_reg_r[MODE_ODD]));
  // break is an all-low frame with framing error
  assign rx_break = rx_frm_err & (rx_word == 12'h000);

  // start edge sync and mid-bit sampling
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_state_r <= RX_IDLE;
      rx_os_r <= 4'h0;
      rx_idx_r <= 4'h0;
      rx_buf_r <= 12'h000;
      rx_armed_r <= 1'b0;
      rx_in_start_r <= 1'b0;
    end else if (!receive_enable) begin
      rx_state_r <= RX_IDLE;
      rx_idx_r <= 4'h0;
      rx_armed_r <= 1'b0;
    end else if (sync_mode_select) begin
      rx_state_r <= RX_IDLE;
      if (rx_done) begin
        rx_idx_r <= 4'h0;
        rx_buf_r <= 12'h000;
      end else if (rx_sync_sample) begin
        rx_buf_r[rx_idx_r] <= i_rxd;
        rx_idx_r <= rx_idx_r + 4'h1;
      end
    end else if (rx_state_r == RX_IDLE) begin
      // A start needs a high line first, so a held break is not re-read
      if (clk_bus.tick16) begin
        if (i_rxd)
          rx_armed_r <= 1'b1;
        else if (rx_armed_r) begin
          rx_state_r <= RX_RECV;
          rx_os_r <= 4'h1;
          rx_idx_r <= 4'h0;
          rx_buf_r <= 12'h000;
          rx_in_start_r <= 1'b1;
          rx_armed_r <= 1'b0;
        end
      end
    end else if (clk_bus.tick16) begin
      rx_os_r <= rx_os_r + 4'h1;
      if (rx_os_r == OS_SAMPLE) begin
        if (rx_in_start_r) begin
          rx_in_start_r <= 1'b0;
          if (i_rxd)
            rx_state_r <= RX_IDLE;
        end else if (rx_done) begin
          rx_state_r <= RX_IDLE;
        end else begin
          rx_buf_r[rx_idx_r] <= i_rxd;
          rx_idx_r <= rx_idx_r + 4'h1;
        end
      end
    end
  end

  // move character when receive data is free
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset)
      receive_data_reg_r <= 8'h00;
    else if (rx_done & !receive_full_flag_r)
      receive_data_reg_r <= rx_data;
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset)
      receive_full_flag_r <= 1'b0;
    else if (rx_done & !receive_full_flag_r & !rx_frm_err & !rx_par_err)
      receive_full_flag_r <= 1'b1;
    else if (clr_bits[ST_RXFULL])
      receive_full_flag_r <= 1'b0;
  end

  // error flags, set wins over clear
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      overrun_error_flag_r <= 1'b0;
      framing_error_flag_r <= 1'b0;
      parity_error_flag_r <= 1'b0;
      break_flag_r <= 1'b0;
    end else begin
      overrun_error_flag_r <= (rx_done & receive_full_flag_r) |
          (overrun_error_flag_r & !clr_bits[ST_OVR]);
      framing_error_flag_r <= (rx_done & rx_frm_err) |
          (framing_error_flag_r & !clr_bits[ST_FRM]);
      parity_error_flag_r <= (rx_done & rx_par_err) |
          (parity_error_flag_r & !clr_bits[ST_PAR]);
      break_flag_r <= (rx_done & rx_break) |
          (break_flag_r & !clr_bits[ST_BRK]);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Serial clock pin and interrupt
  // clock pin function
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_sck <= 1'b1;
      o_sck_oe_n <= 1'b1;
    end else if (sync_mode_select & !serial_control_reg_r[CTRL_CLOCK_ENABLE_HI]) begin
      o_sck <= clk_bus.ser_level;
      o_sck_oe_n <= 1'b0;
    end else if (!sync_mode_select &
                 serial_control_reg_r[CTRL_CLOCK_ENABLE_HI:CTRL_CLOCK_ENABLE_LO] == 2'b01) begin
      // Rises at the centre of each bit
      o_sck <= tx_os_r[3];
      o_sck_oe_n <= 1'b0;
    end else begin
      o_sck <= 1'b1;
      o_sck_oe_n <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset)
      o_irq <= 1'b0;
    else
      o_irq <= |(status_vec & irqen_r);
  end

endmodule

//--- tb/smc_serial_unit_asserts.sv
// Port checker for the serial unit
`timescale 1ns/1ps
module smc_serial_unit_asserts (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [smc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [smc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [smc_pkg::DATA_W-1:0] o_rdata,
  // Serial pins and interrupt
  input wire logic i_rxd,
  input wire logic o_txd,
  input wire logic i_sck,
  input wire logic o_sck,
  input wire logic o_sck_oe_n,
  input wire logic o_irq
);
  import smc_pkg::*;
  logic [7:0] mode_r;
  logic [7:0] ctrl_r;
  logic [7:0] ien_r;
  // Shadows of the mode, control and interrupt enable registers
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      mode_r <= MODE_RST;
      ctrl_r <= CTRL_RST;
      ien_r <= IRQEN_RST;
    end else if (i_wr) begin
      if (i_addr == OFF_MODE) mode_r <= i_wdata;
      if (i_addr == OFF_CTRL) ctrl_r <= i_wdata;
      if (i_addr == OFF_IRQEN) ien_r <= i_wdata;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_te_off;
    !ctrl_r[CTRL_TE] [*4];
  endsequence
  // Pin setup held long enough for the registered enable
  sequence s_pin(logic s, logic [1:0] c);
    (mode_r[MODE_SYNC] == s && ctrl_r[1:0] == c) [*3];
  endsequence
  a_rdata_quiet: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_irq_masked: assert property ((ien_r == 8'h00) [*3] |-> !o_irq)
    else $error("interrupt raised while all enables are off");
  a_pin_port_async: assert property (s_pin(1'b0, 2'b00) |-> o_sck_oe_n)
    else $error("clock pin driven in async internal mode");
  a_pin_drive_async: assert property (s_pin(1'b0, 2'b01) |-> !o_sck_oe_n)
    else $error("clock pin not driven with bit-rate output");
  a_pin_drive_sync: assert property (s_pin(1'b1, 2'b00) |-> !o_sck_oe_n)
    else $error("serial clock not driven in sync internal mode");
  a_pin_input_sync: assert property (s_pin(1'b1, 2'b10) |-> o_sck_oe_n)
    else $error("clock pin driven in sync external mode");
  a_txd_idle_off: assert property (s_te_off |-> o_txd)
    else $error("transmit line low with transmitter off");
  a_txempty_forced: assert property (s_te_off ##0
      (i_rd && i_addr == OFF_STATUS) |=> o_rdata[ST_TXEMPTY])
    else $error("transmit empty not forced with transmitter off");
endmodule

//--- tb/smc_partner.sv
// Far-end serial transceiver model
`timescale 1ns/1ps
module smc_partner (
  // Clock
  input wire logic i_core_clk,
  // Serial pins
  input wire logic i_txd,
  output logic o_rxd,
  output logic o_sck
);
  logic [1:0] cnt_r = 2'h0;
  initial o_rxd = 1'b1;
  // free clock at sixteen ticks per bit
  // Never stopped, so the sampled edges stay evenly spaced
  always @(posedge i_core_clk) begin
    cnt_r <= cnt_r + 2'h1;
    o_sck <= cnt_r[1];
  end
  // low start, LSB first, line back to idle high
  task automatic send(input int bt, input int n, input logic [11:0] f);
    for (int i = 0; i < n; i++) begin
      o_rxd <= f[i];
      repeat (bt) @(posedge i_core_clk);
    end
    o_rxd <= 1'b1;
  endtask
  // sample each bit at its middle
  task automatic capture(input int bt, input int n, output logic [11:0] f,
      output bit ok);
    f = 12'hfff;
    ok = 1'b0;
    for (int k = 0; k < 4000 && !ok; k++) begin
      @(posedge i_core_clk);
      ok = !i_txd;
    end
    repeat (bt / 2) @(posedge i_core_clk);
    for (int i = 0; i < n; i++) begin
      f[i] = i_txd;
      repeat (bt) @(posedge i_core_clk);
    end
  endtask
endmodule

//--- tb/smc_serial_unit_bench.sv
// Self-checking bench for the serial unit
`timescale 1ns/1ps
module smc_serial_unit_bench;
  import smc_pkg::*;
  logic clk;
  logic rst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr_s;
  logic rd_s;
  logic [DATA_W-1:0] rdata;
  logic rxd, txd, sck_far, sck_out, sck_oe_n, irq;
  wire sck_pin = sck_oe_n ? sck_far : sck_out;
  int n_errors = 0;
  int total_checks = 0;
  logic [15:0] seed_r = 16'h9db6;
  smc_serial_unit smc_serial_unit_inst (.i_core_clk(clk), .i_reset(rst),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
    .o_rdata(rdata), .i_rxd(rxd), .o_txd(txd), .i_sck(sck_pin),
    .o_sck(sck_out), .o_sck_oe_n(sck_oe_n), .o_irq(irq));
  smc_partner smc_partner_inst (.i_core_clk(clk), .i_txd(txd),
    .o_rxd(rxd), .o_sck(sck_far));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [7:0] rnd();
    seed_r = {seed_r[14:0], seed_r[15] ^ seed_r[13] ^ seed_r[12] ^ seed_r[10]};
    return seed_r[7:0];
  endfunction
  function automatic logic [7:0] dmask(input logic [7:0] m);
    return (m[MODE_MP] & m[MODE_PE]) ? 8'h1f : (m[MODE_CHR] ? 8'h7f : 8'hff);
  endfunction
  // Frame bits, start first; stop positions stay high
  function automatic logic [11:0] frame(input logic [7:0] m,
      input logic [7:0] d, output int n);
    logic [11:0] f;
    f = {3'h7, d & dmask(m), 1'b0};
    n = $countones(dmask(m)) + 1;
    f |= 12'hfff << n;
    if (m[MODE_PE] & (!m[MODE_MP] | m[MODE_CHR])) begin
      f[n] = (^(d & dmask(m))) ^ m[MODE_ODD];
      n++;
    end else if (m[MODE_MP] & !m[MODE_PE]) begin
      f[n] = 1'b0;
      n++;
    end
    n += m[MODE_STOP] ? 2 : 1;
    return f;
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp,
      input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] msk,
      input logic [7:0] exp, input string what);
    logic [7:0] v;
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
    chk({4'h0, v & msk}, {4'h0, exp}, what);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rxcase(input logic [11:0] f, input logic [7:0] msk,
      input logic [7:0] exp);
    smc_partner_inst.send(32, 11, f);
    @(posedge clk);
    rchk(OFF_STATUS, msk, exp, "rx flags");
  endtask
  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 1000 && irq !== lvl; i++) @(posedge clk);
    if (irq !== lvl) begin
      n_errors++;
      final_report();
    end
  endtask
  initial begin
    logic [7:0] m, d;
    logic [11:0] f, g;
    int n, bt;
    bit ok;
    rst = 1'b1;
    addr = '0;
    wdata = '0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(OFF_STATUS, 8'hff, 8'h06, "status reset");
    rchk(OFF_CLEAR, 8'hff, 8'h00, "unmapped read");
    wr(OFF_BAUD, 8'h01);
    for (int k = 0; k < 6; k++) begin
      m = rnd() & 8'h7c;
      bt = (k == 5) ? 64 : 32;
      wr(OFF_CTRL, 8'h00);
      wr(OFF_MODE, m);
      wr(OFF_CTRL, 8'h30 | ((k == 5) ? 8'h02 : {7'h0, k[0]}));
      d = rnd();
      g = frame(m, d, n);
      wr(OFF_TXDATA, d);
      smc_partner_inst.capture(bt, n, f, ok);
      if (!ok) begin
        n_errors++;
        final_report();
      end
      chk(f, g, "tx frame");
      repeat (2 * bt) @(posedge clk);
      rchk(OFF_STATUS, 8'h06, 8'h06, "tx end");
      wr(OFF_CLEAR, 8'hff);
      d = rnd();
      smc_partner_inst.send(bt, n, frame(m, d, n));
      rchk(OFF_RXDATA, dmask(m), d & dmask(m), "rx data");
      rchk(OFF_STATUS, 8'h79, 8'h01, "rx status");
      $display("format test %0d done", k);
    end
    wr(OFF_CTRL, 8'h00);
    wr(OFF_MODE, 8'h20);
    wr(OFF_CTRL, 8'h30);
    wr(OFF_CLEAR, 8'hff);
    g = frame(8'h20, 8'h3c, n);
    rxcase(g ^ 12'h200, 8'h21, 8'h20);
    rxcase(12'h000, 8'h51, 8'h50);
    wr(OFF_CLEAR, 8'hff);
    rxcase(g, 8'h09, 8'h01);
    rxcase(g, 8'h09, 8'h09);
    $display("rx error test done");
    wr(OFF_CLEAR, 8'hff);
    wr(OFF_IRQEN, 8'h02);
    wr(OFF_TXDATA, 8'h55);
    wait_irq(1'b1);
    chk(irq, 1'b1, "irq tx empty");
    wr(OFF_IRQEN, 8'h04);
    wait_irq(1'b1);
    chk(irq, 1'b1, "irq tx end");
    wr(OFF_CLEAR, 8'h06);
    wait_irq(1'b0);
    chk(irq, 1'b0, "irq cleared");
    $display("irq test done");
    wr(OFF_MODE, 8'h80);
    wr(OFF_CTRL, 8'h00);
    wr(OFF_CTRL, 8'h02);
    rchk(OFF_STATUS, 8'h02, 8'h02, "sync tx empty");
    @(posedge clk);
    $display("sync pin test done");
    final_report();
  end
endmodule
bind smc_serial_unit smc_serial_unit_asserts smc_serial_unit_asserts_inst (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_rxd(i_rxd), .o_txd(o_txd), .i_sck(i_sck), .o_sck(o_sck),
  .o_sck_oe_n(o_sck_oe_n), .o_irq(o_irq));
